// >>> tb/erwc_ready_model.sv
// Purpose: External circuit answering the bus cycle with a ready pin
// Assumes: Ready driven in step with the system clock, so both modes are met
// Notes: Asserts ready a set number of cycles into the strobe
`timescale 1ns/1ps
`default_nettype none
module erwc_ready_model (
    input  wire logic       clk,
    input  wire logic       en,
    input  wire logic       low,
    input  wire logic [7:0] dly,
    input  wire logic       strobe,
    output logic            ready_pin
);
    logic [7:0] cnt_reg;
    logic       act_reg;
    ////////////////////////////////////////////////////////////////////////////
    // Delay count, restarted each cycle; ready held until strobe ends
    always_ff @(posedge clk) begin
        cnt_reg <= strobe ? cnt_reg + 8'h01 : 8'h00;
        act_reg <= en && strobe && (cnt_reg >= dly);
    end
    // Active level follows the polarity in use
    assign ready_pin = act_reg ^ low;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench of the ready wait-state controller
// Assumes: Clock 200 MHz, inputs changed on falling edge
// Notes: Cycle lengths compared between modes and delays
`timescale 1ns/1ps
`default_nettype none
`include "erwc_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("Error %0t: got %0d expected %0d", $time, (a), (b)); end end
module tb_top
    import erwc_pkg::*;
;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    erwc_req_s  req = '0;
    erwc_stat_s stat;
    logic       ready_pin;
    logic       refclk;
    logic       m_en = 1'b0;
    logic       m_low = 1'b0;
    logic [7:0] m_dly = 8'h00;
    int         errors = 0;
    int         tests_run = 0;
    int         ns, na, nw, nl, np, nn;
    logic       saw_wait = 1'b0;
    logic       saw_strobe = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Clock, design and far side
    always #2.5 clk = ~clk;
    erwc_ctrl dut_u (.clk(clk), .srst(srst), .req(req), .ready_pin(ready_pin),
        .stat(stat), .bus_reference_clock_out(refclk));
    erwc_ready_model mdl_u (.clk(clk), .en(m_en), .low(m_low), .dly(m_dly),
        .strobe(stat.strobe), .ready_pin(ready_pin));
    ////////////////////////////////////////////////////////////////////////////
    // One bus cycle, returns edges from start to done
    task automatic run(input logic [5:0] ap, input logic as, input logic low,
        input logic use_r, input logic [7:0] d, output int n);
        @(negedge clk);
        m_en = use_r;
        m_low = low;
        m_dly = d;
        // Start at a fixed phase of the reference clock so counts repeat
        @(posedge refclk);
        @(negedge clk);
        req = '{1'b1, use_r, low, as, ap};
        saw_wait = 1'b0;
        saw_strobe = 1'b0;
        @(negedge clk);
        req.start = 1'b0;
        n = 1;
        while (stat.done !== 1'b1 && n < 600) begin
            saw_wait = saw_wait | stat.ready_wait_phase;
            saw_strobe = saw_strobe | stat.strobe;
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        `CHK(stat.done, 1'b0)
        repeat (2) @(negedge clk);
        `CHK(stat.busy, 1'b0)
    endtask
    // Reference clock high time in system clock cycles
    task automatic t_refclk();
        int c;
        c = 0;
        @(posedge refclk);
        @(negedge clk);
        while (refclk === 1'b1 && c < 20) begin
            @(negedge clk);
            c++;
        end
        `CHK(c, `ERWC_CLK_DIV)
        $display("t_refclk ends, %0d cycles high", c);
    endtask
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_sync();
        run(6'h01, 1'b0, 1'b0, 1'b1, 8'h00, ns);
        `CHK(ns < 600, 1'b1)
        `CHK(saw_wait, 1'b1)
        `CHK(saw_strobe, 1'b1)
        $display("t_sync ends, %0d edges", ns);
    endtask
    task automatic t_async();
        run(6'h01, 1'b1, 1'b0, 1'b1, 8'h00, na);
        `CHK(na > ns, 1'b1)
        `CHK(na < 600, 1'b1)
        $display("t_async ends, %0d edges", na);
    endtask
    task automatic t_wait();
        run(6'h01, 1'b0, 1'b0, 1'b1, 8'h1E, nw);
        `CHK(nw > 30, 1'b1)
        `CHK(nw < 600, 1'b1)
        $display("t_wait ends, %0d edges", nw);
    endtask
    task automatic t_low();
        run(6'h01, 1'b0, 1'b1, 1'b1, 8'h1E, nl);
        `CHK(nl, nw)
        `CHK(nl > 30, 1'b1)
        $display("t_low ends, %0d edges", nl);
    endtask
    task automatic t_access();
        run(6'h08, 1'b0, 1'b0, 1'b1, 8'h00, np);
        `CHK(np >= 32, 1'b1)
        `CHK(np < 600, 1'b1)
        $display("t_access ends, %0d edges", np);
    endtask
    task automatic t_noready();
        run(6'h01, 1'b0, 1'b0, 1'b0, 8'h00, nn);
        `CHK(nn < 600, 1'b1)
        `CHK(saw_wait, 1'b0)
        $display("t_noready ends, %0d edges", nn);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (5) @(negedge clk);
        srst = 1'b0;
        `CHK(stat.busy, 1'b0)
        t_refclk();
        t_sync();
        t_async();
        t_wait();
        t_low();
        t_access();
        t_noready();
        stop_test();
    end
    initial begin
        #50000;
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire

// >>> verilog/erwc_ctrl.sv
// Purpose: Bus cycle wait-state control by external ready
// Assumes: One system clock, reference clock made by divider enable
// Notes: Cycle starts on req.start while idle
`timescale 1ns/1ps
`default_nettype none
`include "erwc_regs.svh"
module erwc_ctrl
    import erwc_pkg::*;
#(
    parameter logic [3:0] CLK_DIV = `ERWC_CLK_DIV
) (
    input  wire logic      clk,
    input  wire logic      srst,
    input  wire erwc_req_s req,
    input  wire logic      ready_pin,
    output erwc_stat_s     stat,
    output logic           bus_reference_clock_out
);
    erwc_state_e state_reg;
    logic [3:0]  div_reg;
    logic        tick;
    logic [5:0]  acc_reg;
    logic        ready_hi;
    logic        async_reg;
    logic        low_reg;
    logic        use_reg;
    logic        delay_reg;
    erwc_stat_s  stat_reg;
    logic        clk_out_reg;

    ////////////////////////////////////////////////////////////////////////
    // Ready conditioning
    erwc_ready_in u_rdy (
        .clk        (clk),
        .srst       (srst),
        .ready_raw  (ready_pin),
        .ready_low  (low_reg),
        .async_mode (async_reg),
        .ready_hi   (ready_hi)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reference clock divider, tick is one phase
    always_ff @(posedge clk) begin
        if (srst) begin
            div_reg     <= 4'h0;
            clk_out_reg <= 1'b0;
        end else if (div_reg == CLK_DIV - 4'h1) begin
            div_reg     <= 4'h0;
            clk_out_reg <= ~clk_out_reg;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end
    assign tick = (div_reg == CLK_DIV - 4'h1) && clk_out_reg;

    ////////////////////////////////////////////////////////////////////////
    // Cycle configuration latched at start
    always_ff @(posedge clk) begin
        if (srst) begin
            async_reg <= 1'b0;
            low_reg   <= 1'b0;
            use_reg   <= 1'b0;
        end else if (state_reg == ERWC_IDLE && req.start) begin
            async_reg <= req.async_mode;
            low_reg   <= req.ready_low;
            use_reg   <= req.use_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencing
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ERWC_IDLE;
            acc_reg   <= 6'h00;
            delay_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ERWC_IDLE: begin
                    if (req.start) begin
                        state_reg <= ERWC_ACCESS;
                        acc_reg   <= (req.access_phase < `ERWC_ACC_MIN) ? `ERWC_ACC_MIN :
                                     (req.access_phase > `ERWC_ACC_MAX) ? `ERWC_ACC_MAX :
                                     req.access_phase;
                    end
                end
                ERWC_ACCESS: begin
                    if (tick) begin
                        if (acc_reg > 6'h01) begin
                            acc_reg <= acc_reg - 6'h01;
                        end else if (!use_reg) begin
                            state_reg <= ERWC_END;
                        end else begin
                            state_reg <= ERWC_RDYW;
                            delay_reg <= async_reg;
                        end
                    end
                end
                ERWC_RDYW: begin
                    if (tick) begin
                        if (delay_reg) begin
                            delay_reg <= 1'b0;
                        end else if (ready_hi) begin
                            state_reg <= ERWC_END;
                        end
                    end
                end
                ERWC_END: begin
                    state_reg <= ERWC_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered status
    always_ff @(posedge clk) begin
        if (srst) begin
            stat_reg <= '0;
        end else begin
            stat_reg.busy   <= (state_reg != ERWC_IDLE);
            stat_reg.strobe <= (state_reg == ERWC_ACCESS) || (state_reg == ERWC_RDYW);
            stat_reg.done   <= (state_reg == ERWC_END);
            stat_reg.ready_wait_phase <= (state_reg == ERWC_RDYW);
        end
    end

    assign stat = stat_reg;
    assign bus_reference_clock_out = clk_out_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_ready_ends: assert property (@(posedge clk) disable iff (srst)
        state_reg == ERWC_RDYW && tick && !delay_reg && ready_hi |=> state_reg == ERWC_END)
        else $error("Active ready did not end cycle");
    a_not_ready_waits: assert property (@(posedge clk) disable iff (srst)
        state_reg == ERWC_RDYW && tick && !ready_hi |=> state_reg == ERWC_RDYW)
        else $error("Inactive ready did not insert wait");
    a_access_first: assert property (@(posedge clk) disable iff (srst)
        state_reg == ERWC_ACCESS && acc_reg > 6'h01 |=> state_reg == ERWC_ACCESS)
        else $error("Access phase cut short");
    a_async_extra_wait: assert property (@(posedge clk) disable iff (srst)
        $rose(state_reg == ERWC_RDYW) && async_reg |-> delay_reg)
        else $error("Async mode missing wait state");
    a_sync_no_delay: assert property (@(posedge clk) disable iff (srst)
        $rose(state_reg == ERWC_RDYW) && !async_reg |-> !delay_reg)
        else $error("Sync mode sampled late");
    a_end_idle: assert property (@(posedge clk) disable iff (srst)
        state_reg == ERWC_END |=> state_reg == ERWC_IDLE ##1 !stat.busy)
        else $error("Cycle end not followed by idle");
    a_polarity_fixed: assert property (@(posedge clk) disable iff (srst)
        state_reg != ERWC_IDLE |=> $stable(low_reg))
        else $error("Polarity changed in cycle");
    a_wait_status: assert property (@(posedge clk) disable iff (srst)
        state_reg == ERWC_RDYW |=> stat.ready_wait_phase)
        else $error("Wait status missing");
    c_sync_cycle: cover property (@(posedge clk) disable iff (srst)
        state_reg == ERWC_RDYW && !async_reg ##1 state_reg == ERWC_END);
    c_async_cycle: cover property (@(posedge clk) disable iff (srst)
        state_reg == ERWC_RDYW && async_reg ##1 state_reg == ERWC_END);
    c_no_ready: cover property (@(posedge clk) disable iff (srst)
        state_reg == ERWC_ACCESS && !use_reg ##1 state_reg == ERWC_END);
endmodule
`default_nettype wire

// >>> verilog/erwc_pkg.sv
// Purpose: Types for the external bus ready wait-state controller
// Assumes: Included constants header
// Notes: None
package erwc_pkg;
    typedef enum logic [1:0] {
        ERWC_IDLE   = 2'b00,
        ERWC_ACCESS = 2'b01,
        ERWC_RDYW   = 2'b11,
        ERWC_END    = 2'b10
    } erwc_state_e;

    typedef struct packed {
        logic       start;
        logic       use_ready;
        logic       ready_low;
        logic       async_mode;
        logic [5:0] access_phase;
    } erwc_req_s;

    typedef struct packed {
        logic busy;
        logic strobe;
        logic done;
        logic ready_wait_phase;
    } erwc_stat_s;
endpackage

// >>> verilog/erwc_ready_in.sv
// Purpose: Ready input conditioning: polarity and optional synchroniser
// Assumes: Raw ready sampled as synchronous input
// Notes: Output is active-high ready
`timescale 1ns/1ps
`default_nettype none
module erwc_ready_in
    import erwc_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ready_raw,
    input  wire logic ready_low,
    input  wire logic async_mode,
    output logic      ready_hi
);
    logic pol_reg;
    logic sync1_reg;
    logic sync2_reg;

    // Polarity applied before any sampling
    always_ff @(posedge clk) begin
        if (srst) begin
            pol_reg <= 1'b0;
        end else begin
            pol_reg <= ready_raw ^ ready_low;
        end
    end

    // Two extra synchroniser stages for asynchronous ready
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= pol_reg;
            sync2_reg <= sync1_reg;
        end
    end

    assign ready_hi = async_mode ? sync2_reg : pol_reg;
endmodule
`default_nettype wire

// >>> verilog/erwc_regs.svh
// Purpose: Constants for the external bus ready wait-state controller
// Assumes: Single 200 MHz system clock
// Notes: Bus reference clock is a divided enable of the system clock
//
// Overview of operation
// - Ready input lengthens or ends each bus cycle started with use_ready set; active level is configurable
// - Asynchronous mode adds two synchroniser stages, at least one extra wait state
// - Inactive ready at sample point inserts one more wait phase
// - Active ready at sample point ends the running bus cycle
// - Synchronous and asynchronous modes sample ready at different points
// - Mandatory access-phase wait states complete before ready is used
`ifndef ERWC_REGS_SVH
`define ERWC_REGS_SVH

`define ERWC_CLK_DIV        4'h2
`define ERWC_ACC_MIN        6'h01
`define ERWC_ACC_MAX        6'h20
`define ERWC_SYNC_SAMPLE_OFS 4'h0
`define ERWC_ASYNC_SAMPLE_OFS 4'h1

`endif
